// ### common/conversion_result_word_pkg.sv
package arcr_pkg;
    // cpu byte addresses
    localparam logic [15:0] RESULT_WORD_ADDR = 16'hFF08;
    localparam logic [15:0] RESULT_WORD_HI_ADDR = 16'hFF09;
    localparam logic [15:0] RESULT_BYTE_ADDR = 16'hFF1F;
    localparam logic [15:0] CHAN_SEL_ADDR = 16'hFF29;
    localparam logic [15:0] PIN_CFG_ADDR = 16'hFF2F;
    // reset values
    localparam logic [15:0] RESULT_WORD_RST = 16'h0000;
    localparam logic [7:0] RESULT_BYTE_RST = 8'h00;
    localparam logic [2:0] CHAN_SEL_RST = 3'h0;
    localparam logic [3:0] PIN_CFG_RST = 4'h0;
    // field layout
    localparam int RESULT_LSB_POS = 6;
    localparam int SAR_W = 10;
    localparam int CHAN_W = 3;
    localparam int SPLIT_W = 4;
    localparam int PIN_COUNT = 8;
    localparam logic [3:0] SPLIT_MAX = 4'h8;

    typedef struct packed {
        logic rd;
        logic wr;
        logic word;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [7:0] wmask;
    } arcr_bus_req_t;

    typedef enum logic [1:0] {
        ARCR_IDLE = 2'b00,
        ARCR_WAIT = 2'b01,
        ARCR_ACK = 2'b10
    } arcr_state_t;
endpackage

// ### hw/conversion_result_word_regs.sv
`timescale 1ns/1ps
// Behaviour
// - 16-bit result at FF08/FF09, read-only, resets zero
// - channel/pin writes leave held result intact
// - result reads get one wait cycle
// - channel/pin config writes get one wait cycle
// - byte result holds upper eight bits, resets zero
// - byte result readable only by byte access
// - channel select byte at FF29, resets zero
// - three low bits pick input zero to seven
// - pin config byte at FF2F, resets all analog
// - field k makes k lowest pins digital
// - word: high byte upper bits, low two on top
// - both results load from sar at conversion end
module arcr_regs (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // cpu access
    input arcr_pkg::arcr_bus_req_t bus_req,
    output logic bus_ack,
    output logic [15:0] bus_rdata,
    // conversion core
    input wire logic conv_done,
    input wire logic [arcr_pkg::SAR_W-1:0] sar_value,
    output logic [arcr_pkg::CHAN_W-1:0] chan_sel,
    output logic chan_rewritten,
    // shared pins
    output logic [arcr_pkg::PIN_COUNT-1:0] pin_is_analog
);
    arcr_pkg::arcr_state_t st_reg;
    arcr_pkg::arcr_state_t st_next;
    arcr_pkg::arcr_bus_req_t req_reg;
    arcr_pkg::arcr_bus_req_t cur_req;
    logic [15:0] result_word_reg;
    logic [7:0] result_byte_reg;
    logic [arcr_pkg::CHAN_W-1:0] chan_reg;
    logic [arcr_pkg::SPLIT_W-1:0] split_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic chan_rew_reg;
    logic accept;
    logic need_wait;
    logic wr_chan;
    logic wr_pin;

    assign accept = (st_reg == arcr_pkg::ARCR_IDLE) && (bus_req.rd || bus_req.wr);
    assign cur_req = (st_reg == arcr_pkg::ARCR_IDLE) ? bus_req : req_reg;
    assign wr_chan = accept && bus_req.wr && (bus_req.addr == arcr_pkg::CHAN_SEL_ADDR);
    assign wr_pin = accept && bus_req.wr && (bus_req.addr == arcr_pkg::PIN_CFG_ADDR);

    // waited accesses
    always_comb begin
        need_wait = 1'b0;
        if (bus_req.rd && (bus_req.addr == arcr_pkg::RESULT_WORD_ADDR ||
                bus_req.addr == arcr_pkg::RESULT_WORD_HI_ADDR ||
                bus_req.addr == arcr_pkg::RESULT_BYTE_ADDR)) begin
            need_wait = 1'b1;
        end
        if (bus_req.wr && (bus_req.addr == arcr_pkg::CHAN_SEL_ADDR ||
                bus_req.addr == arcr_pkg::PIN_CFG_ADDR)) begin
            need_wait = 1'b1;
        end
    end

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            arcr_pkg::ARCR_IDLE: begin
                if (accept) begin
                    st_next = need_wait ? arcr_pkg::ARCR_WAIT : arcr_pkg::ARCR_ACK;
                end
            end
            arcr_pkg::ARCR_WAIT: begin
                st_next = arcr_pkg::ARCR_ACK;
            end
            arcr_pkg::ARCR_ACK: begin
                st_next = arcr_pkg::ARCR_IDLE;
            end
            default: begin
                st_next = arcr_pkg::ARCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= arcr_pkg::ARCR_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_reg <= '0;
        end else if (accept) begin
            req_reg <= bus_req;
        end
    end

    // read data decode
    always_comb begin
        rdata_next = 16'h0000;
        if (cur_req.rd) begin
            case (cur_req.addr)
                arcr_pkg::RESULT_WORD_ADDR: begin
                    rdata_next = cur_req.word ? result_word_reg : {8'h00, result_word_reg[7:0]};
                end
                arcr_pkg::RESULT_WORD_HI_ADDR: begin
                    rdata_next = {8'h00, result_word_reg[15:8]};
                end
                arcr_pkg::RESULT_BYTE_ADDR: begin
                    rdata_next = cur_req.word ? 16'h0000 : {8'h00, result_byte_reg};
                end
                arcr_pkg::CHAN_SEL_ADDR: begin
                    rdata_next = {13'h0, chan_reg};
                end
                arcr_pkg::PIN_CFG_ADDR: begin
                    rdata_next = {12'h000, split_reg};
                end
                default: begin
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= 16'h0000;
        end else if (st_next == arcr_pkg::ARCR_ACK) begin
            rdata_reg <= rdata_next;
        end
    end

    assign bus_ack = (st_reg == arcr_pkg::ARCR_ACK);
    assign bus_rdata = rdata_reg;

    // results: held across config writes, which permits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_word_reg <= arcr_pkg::RESULT_WORD_RST;
            result_byte_reg <= arcr_pkg::RESULT_BYTE_RST;
        end else if (conv_done) begin
            result_word_reg <= {sar_value, 6'h00};
            result_byte_reg <= sar_value[arcr_pkg::SAR_W-1:2];
        end
    end

    // channel select, masked for bit access
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chan_reg <= arcr_pkg::CHAN_SEL_RST;
        end else if (wr_chan) begin
            chan_reg <= (chan_reg & ~bus_req.wmask[2:0]) | (bus_req.wdata[2:0] & bus_req.wmask[2:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chan_rew_reg <= 1'b0;
        end else begin
            chan_rew_reg <= wr_chan;
        end
    end

    // pin split field
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            split_reg <= arcr_pkg::PIN_CFG_RST;
        end else if (wr_pin) begin
            split_reg <= (split_reg & ~bus_req.wmask[3:0]) | (bus_req.wdata[3:0] & bus_req.wmask[3:0]);
        end
    end

    assign chan_sel = chan_reg;
    assign chan_rewritten = chan_rew_reg;

    // per-pin analog or digital; prohibited codes above eight give all digital
    genvar gi;
    generate
        for (gi = 0; gi < arcr_pkg::PIN_COUNT; gi++) begin : g_pin
            assign pin_is_analog[gi] = (split_reg <= 4'(gi));
        end
    endgenerate

    // checks
    property p_result_reset;
        @(posedge clk) sys_rst |=> (result_word_reg == 16'h0000) && (result_byte_reg == 8'h00);
    endproperty
    a_result_reset: assert property (p_result_reset) else $error("result not cleared by reset");

    property p_low_zero;
        @(posedge clk) disable iff (sys_rst) result_word_reg[5:0] == 6'h00;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("result low bits not zero");

    property p_byte_tracks;
        @(posedge clk) disable iff (sys_rst) result_byte_reg == result_word_reg[15:8];
    endproperty
    a_byte_tracks: assert property (p_byte_tracks) else $error("byte result differs from word");

    property p_load;
        @(posedge clk) disable iff (sys_rst) conv_done |=> result_word_reg == {$past(sar_value), 6'h00};
    endproperty
    a_load: assert property (p_load) else $error("result not loaded at conversion end");

    property p_read_wait;
        @(posedge clk) disable iff (sys_rst)
            (st_reg == arcr_pkg::ARCR_IDLE && bus_req.rd && bus_req.addr == arcr_pkg::RESULT_WORD_ADDR)
            |=> !bus_ack ##1 bus_ack;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("result read without wait cycle");

    property p_write_wait;
        @(posedge clk) disable iff (sys_rst) (wr_chan || wr_pin) |=> !bus_ack ##1 bus_ack;
    endproperty
    a_write_wait: assert property (p_write_wait) else $error("config write without wait cycle");

    property p_byte_word_read;
        @(posedge clk) disable iff (sys_rst)
            (accept && bus_req.rd && bus_req.word && bus_req.addr == arcr_pkg::RESULT_BYTE_ADDR)
            |-> ##2 (bus_ack && bus_rdata == 16'h0000);
    endproperty
    a_byte_word_read: assert property (p_byte_word_read) else $error("byte result read by word access");

    property p_chan_write;
        @(posedge clk) disable iff (sys_rst)
            (wr_chan && bus_req.wmask == 8'hFF) |=> chan_sel == $past(bus_req.wdata[2:0]) && chan_rewritten;
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("channel select write lost");

    property p_upper_zero;
        @(posedge clk) disable iff (sys_rst)
            (accept && bus_req.rd && bus_req.addr == arcr_pkg::CHAN_SEL_ADDR) |=> bus_ack && bus_rdata[15:3] == 13'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("reserved channel bits not zero");

    property p_split;
        @(posedge clk) disable iff (sys_rst)
            split_reg <= arcr_pkg::SPLIT_MAX |-> pin_is_analog == 8'(~((9'h001 << split_reg) - 9'h001));
    endproperty
    a_split: assert property (p_split) else $error("pin split decode wrong");

    c_load: cover property (@(posedge clk) disable iff (sys_rst) conv_done);
    c_waited_read: cover property (@(posedge clk) disable iff (sys_rst) st_reg == arcr_pkg::ARCR_WAIT && req_reg.rd);
    c_chan_write: cover property (@(posedge clk) disable iff (sys_rst) wr_chan);
    c_pin_write: cover property (@(posedge clk) disable iff (sys_rst) wr_pin ##1 split_reg == 4'h8);
endmodule

// ### bench/conversion_result_word_core_model.sv
`timescale 1ns/1ps
module arcr_core_model (
    // clock
    input wire logic clk,
    // bench control
    input wire logic go,
    input wire logic [9:0] value,
    // result toward registers
    output logic conv_done,
    output logic [9:0] sar_value
);
    // value is only meaningful with conv_done, otherwise it keeps changing
    always_ff @(posedge clk) begin
        conv_done <= go;
        sar_value <= go ? value : ~sar_value;
    end
endmodule

// ### bench/conversion_result_word_regs_tb_top.sv
`timescale 1ns/1ps
module arcr_regs_tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    arcr_pkg::arcr_bus_req_t bus_req = '0;
    logic bus_ack;
    logic [15:0] bus_rdata;
    logic go = 1'b0;
    logic [9:0] conv_val = 10'h000;
    logic conv_done;
    logic [9:0] sar_value;
    logic [2:0] chan_sel;
    logic chan_rewritten;
    logic [7:0] pin_is_analog;
    logic [15:0] rd_data;
    logic rew_flag;
    logic [7:0] exp_pins;
    int miscompares = 0;
    int n_checks = 0;
    // clock never stops, so waited accesses always complete
    always #4 clk = ~clk;
    arcr_regs dut_u (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
        .conv_done(conv_done), .sar_value(sar_value), .chan_sel(chan_sel), .chan_rewritten(chan_rewritten),
        .pin_is_analog(pin_is_analog));
    arcr_core_model core_u (.clk(clk), .go(go), .value(conv_val), .conv_done(conv_done), .sar_value(sar_value));
    task automatic close_out;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one access, held through the edge that samples ack; latency counted from the taking edge
    task automatic acc(input logic wr, input logic word, input logic [15:0] addr, input logic [15:0] wdata,
        input logic [7:0] wmask, input int waits);
        int n;
        bus_req.rd = ~wr;
        bus_req.wr = wr;
        bus_req.word = word;
        bus_req.addr = addr;
        bus_req.wdata = wdata;
        bus_req.wmask = wmask;
        @(negedge clk);
        n = 1;
        rew_flag = chan_rewritten;
        while (bus_ack !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (n == 8) begin
            miscompares++;
            close_out();
        end
        chk(16'(n), 16'(waits));
        rd_data = bus_rdata;
        @(posedge clk);
        @(negedge clk);
        bus_req.rd = 1'b0;
        bus_req.wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic wr8(input logic [15:0] addr, input logic [7:0] d, input logic [7:0] m, input int waits);
        acc(1'b1, 1'b0, addr, {8'h00, d}, m, waits);
    endtask
    task automatic rd8(input logic [15:0] addr, input int waits, input logic [7:0] exp);
        acc(1'b0, 1'b0, addr, 16'h0000, 8'h00, waits);
        chk(rd_data & 16'h00FF, {8'h00, exp});
    endtask
    task automatic rd16(input logic [15:0] addr, input int waits, input logic [15:0] exp);
        acc(1'b0, 1'b1, addr, 16'h0000, 8'h00, waits);
        chk(rd_data, exp);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        chk({8'h00, pin_is_analog}, 16'h00FF);
        chk({13'h0, chan_sel}, 16'h0000);
        rd16(arcr_pkg::RESULT_WORD_ADDR, 2, arcr_pkg::RESULT_WORD_RST);
        rd8(arcr_pkg::RESULT_BYTE_ADDR, 2, arcr_pkg::RESULT_BYTE_RST);
        rd8(arcr_pkg::CHAN_SEL_ADDR, 1, 8'h00);
        rd8(arcr_pkg::PIN_CFG_ADDR, 1, 8'h00);
        for (int k = 0; k <= 8; k++) begin
            wr8(arcr_pkg::PIN_CFG_ADDR, 8'hF0 | 8'(k), 8'hFF, 2);
            chk({15'h0, rew_flag}, 16'h0000);
            exp_pins = 8'hFF << k;
            chk({8'h00, pin_is_analog}, {8'h00, exp_pins});
            rd8(arcr_pkg::PIN_CFG_ADDR, 1, 8'(k));
        end
        wr8(arcr_pkg::PIN_CFG_ADDR, 8'h00, 8'hFF, 2);
        for (int c = 0; c < 8; c++) begin
            wr8(arcr_pkg::CHAN_SEL_ADDR, 8'(c), 8'hFF, 2);
            chk({15'h0, rew_flag}, 16'h0001);
            chk({13'h0, chan_sel}, 16'(c));
            rd8(arcr_pkg::CHAN_SEL_ADDR, 1, 8'(c));
        end
        wr8(arcr_pkg::CHAN_SEL_ADDR, 8'h00, 8'h02, 2);
        chk({13'h0, chan_sel}, 16'h0005);
        acc(1'b1, 1'b1, arcr_pkg::PIN_CFG_ADDR, 16'h0503, 8'hFF, 2);
        chk({8'h00, pin_is_analog}, 16'h00F8);
        for (int i = 0; i < 2; i++) begin
            conv_val = i == 0 ? 10'h2D5 : 10'h12B;
            go = 1'b1;
            @(negedge clk);
            go = 1'b0;
            repeat (2) @(negedge clk);
            rd16(arcr_pkg::RESULT_WORD_ADDR, 2, {conv_val, 6'h00});
            rd8(arcr_pkg::RESULT_WORD_HI_ADDR, 2, conv_val[9:2]);
            rd8(arcr_pkg::RESULT_WORD_ADDR, 2, {conv_val[1:0], 6'h00});
            rd8(arcr_pkg::RESULT_BYTE_ADDR, 2, conv_val[9:2]);
            rd16(arcr_pkg::RESULT_BYTE_ADDR, 2, 16'h0000);
            acc(1'b1, 1'b1, arcr_pkg::RESULT_WORD_ADDR, 16'hFFFF, 8'hFF, 1);
            rd16(arcr_pkg::RESULT_WORD_ADDR, 2, {conv_val, 6'h00});
        end
        rd16(16'hFF00, 1, 16'h0000);
        close_out();
    end
endmodule
